// >>> common/jtg_defines.vh
// Constants for the boundary-scan instruction decode block
`ifndef JTG_DEFINES_VH
`define JTG_DEFINES_VH

// ----------------------------------------------------------------
// Instruction register
// ----------------------------------------------------------------
`define JTG_IR_W        4
`define JTG_IR_CAPTURE  4'h1
`define JTG_OP_EXTEST   4'h0
`define JTG_OP_SAMPLE   4'h1
`define JTG_OP_IDCODE   4'h2
`define JTG_OP_HIGHZ    4'h4
`define JTG_OP_BYPASS   4'hF

// ----------------------------------------------------------------
// Identification register layout
// ----------------------------------------------------------------
`define JTG_ID_W        32
`define JTG_ID_VER_MSB  31
`define JTG_ID_VER_LSB  28
`define JTG_ID_PART_MSB 27
`define JTG_ID_PART_LSB 12
`define JTG_ID_MFR_MSB  11
`define JTG_ID_MFR_LSB  1
`define JTG_ID_LSB_VAL  1'h1
`define JTG_ID_VER_W    4
`define JTG_ID_PART_W   16
`define JTG_ID_MFR_W    11

// ----------------------------------------------------------------
// Boundary chain default length
// ----------------------------------------------------------------
`define JTG_BSR_LEN     8

`endif

// >>> rtl/jtg_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module jtg_sync #(
    parameter RST_VAL = 1'b0          // Level shown during reset
) (
    // Clock and reset
    input  wire clk_sys,
    input  wire rst,
    // Pin side and filtered level
    input  wire pin_in,
    output reg  lvl_r
);

    reg s1_r;                         // Metastable stage, read by s2 only
    reg s2_r;                         // Second stage
    reg s3_r;                         // Third stage

    // ------------------------------------------------------------
    // Shift chain; level moves only when the last two stages agree
    // ------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1_r  <= RST_VAL;
            s2_r  <= RST_VAL;
            s3_r  <= RST_VAL;
            lvl_r <= RST_VAL;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // A glitch seen by one stage alone is rejected
            if (s2_r == s3_r) begin
                lvl_r <= s3_r;
            end
        end
    end

endmodule // jtg_sync

`default_nettype wire

// >>> rtl/jtg_tap_decode.v
// Boundary-scan port: TAP sequencer, instruction decode, data registers
`timescale 1ns/1ps
`default_nettype none
`include "jtg_defines.vh"

module jtg_tap_decode #(
    parameter BSR_LEN = `JTG_BSR_LEN,  // Boundary cells
    parameter [3:0]  ID_VER  = 4'h6,    // Arbitrary value
    parameter [15:0] ID_PART = 16'h1E7A,// Arbitrary value
    parameter [10:0] ID_MFR  = 11'h2C9  // Arbitrary value
) (
    // System clock and reset
    input  wire               clk_sys,
    input  wire               rst,
    // Test port pins from the controller
    input  wire               tck,
    input  wire               tms,
    input  wire               tdi,
    input  wire               trst_n,
    // Test data out, pin with enable
    output reg                tdo_r,
    output reg                tdo_oe_r,
    // Core side of the pads
    input  wire [BSR_LEN-1:0] core_out,
    input  wire [BSR_LEN-1:0] core_oe,
    input  wire [BSR_LEN-1:0] pad_in,
    // Pad drivers
    output reg  [BSR_LEN-1:0] pad_out_r,
    output reg  [BSR_LEN-1:0] pad_oe_r,
    // Current instruction, for observation
    output reg  [3:0]         ir_cur_r
);

    // ------------------------------------------------------------
    // TAP states
    // ------------------------------------------------------------
    localparam [3:0] S_TLR  = 4'h0;
    localparam [3:0] S_RTI  = 4'h1;
    localparam [3:0] S_SDR  = 4'h2;
    localparam [3:0] S_CDR  = 4'h3;
    localparam [3:0] S_SHDR = 4'h4;
    localparam [3:0] S_E1DR = 4'h5;
    localparam [3:0] S_PDR  = 4'h6;
    localparam [3:0] S_E2DR = 4'h7;
    localparam [3:0] S_UDR  = 4'h8;
    localparam [3:0] S_SIR  = 4'h9;
    localparam [3:0] S_CIR  = 4'hA;
    localparam [3:0] S_SHIR = 4'hB;
    localparam [3:0] S_E1IR = 4'hC;
    localparam [3:0] S_PIR  = 4'hD;
    localparam [3:0] S_E2IR = 4'hE;
    localparam [3:0] S_UIR  = 4'hF;

    // Identification word assembled from fields
    localparam [31:0] ID_WORD = {ID_VER, ID_PART, ID_MFR,
                                 `JTG_ID_LSB_VAL};

    // ------------------------------------------------------------
    // Synchronised pins
    // ------------------------------------------------------------
    wire tck_l;                       // Filtered test clock
    wire tms_l;                       // Filtered mode select
    wire tdi_l;                       // Filtered data in
    wire trst_n_l;                    // Filtered test reset

    // Test clock idles high; a matching reset level avoids a false edge
    jtg_sync #(.RST_VAL(1'b1)) u_sync_tck (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin_in  (tck),
        .lvl_r   (tck_l)
    );
    jtg_sync #(.RST_VAL(1'b1)) u_sync_tms (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin_in  (tms),
        .lvl_r   (tms_l)
    );
    jtg_sync #(.RST_VAL(1'b0)) u_sync_tdi (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin_in  (tdi),
        .lvl_r   (tdi_l)
    );
    jtg_sync #(.RST_VAL(1'b0)) u_sync_trst (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin_in  (trst_n),
        .lvl_r   (trst_n_l)
    );

    // ------------------------------------------------------------
    // State and data registers
    // ------------------------------------------------------------
    reg               tck_d_r;        // Previous test clock level
    reg  [3:0]        state_r;        // TAP state
    reg  [3:0]        state_nxt;      // Next TAP state
    reg  [3:0]        ir_sh_r;        // Instruction shift stage
    reg               byp_r;          // One-stage bypass
    reg  [31:0]       id_sh_r;        // Identification shifter
    reg  [BSR_LEN-1:0] bsr_sh_r;      // Boundary shift stage
    reg  [BSR_LEN-1:0] bsr_upd_r;     // Boundary update latch

    wire tck_rise = tck_l & ~tck_d_r; // Rising test clock edge
    wire tck_fall = ~tck_l & tck_d_r; // Falling test clock edge

    // Path selection from the current instruction
    wire sel_bsr = (ir_cur_r == `JTG_OP_EXTEST) |
                   (ir_cur_r == `JTG_OP_SAMPLE);
    wire sel_id  = (ir_cur_r == `JTG_OP_IDCODE);
    wire sel_byp = ~sel_bsr & ~sel_id;

    // ------------------------------------------------------------
    // TAP next state, taken on tms at each rising edge
    // ------------------------------------------------------------
    always @* begin
        case (state_r)
            S_TLR:   state_nxt = tms_l ? S_TLR  : S_RTI;
            S_RTI:   state_nxt = tms_l ? S_SDR  : S_RTI;
            S_SDR:   state_nxt = tms_l ? S_SIR  : S_CDR;
            S_CDR:   state_nxt = tms_l ? S_E1DR : S_SHDR;
            S_SHDR:  state_nxt = tms_l ? S_E1DR : S_SHDR;
            S_E1DR:  state_nxt = tms_l ? S_UDR  : S_PDR;
            S_PDR:   state_nxt = tms_l ? S_E2DR : S_PDR;
            S_E2DR:  state_nxt = tms_l ? S_UDR  : S_SHDR;
            S_UDR:   state_nxt = tms_l ? S_SDR  : S_RTI;
            S_SIR:   state_nxt = tms_l ? S_TLR  : S_CIR;
            S_CIR:   state_nxt = tms_l ? S_E1IR : S_SHIR;
            S_SHIR:  state_nxt = tms_l ? S_E1IR : S_SHIR;
            S_E1IR:  state_nxt = tms_l ? S_UIR  : S_PIR;
            S_PIR:   state_nxt = tms_l ? S_E2IR : S_PIR;
            S_E2IR:  state_nxt = tms_l ? S_UIR  : S_SHIR;
            S_UIR:   state_nxt = tms_l ? S_SDR  : S_RTI;
            default: state_nxt = S_TLR;
        endcase
    end

    // ------------------------------------------------------------
    // Rising edge: state advance, capture and shift
    // ------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tck_d_r  <= 1'b1;
            state_r  <= S_TLR;
            ir_sh_r  <= 4'h0;
            byp_r    <= 1'b0;
            id_sh_r  <= 32'h00000000;
            bsr_sh_r <= {BSR_LEN{1'b0}};
        end else begin
            tck_d_r <= tck_l;
            if (!trst_n_l) begin
                // Test reset pin forces the reset state at once
                state_r <= S_TLR;
            end else if (tck_rise) begin
                state_r <= state_nxt;
                case (state_r)
                    S_CIR: begin
                        ir_sh_r <= `JTG_IR_CAPTURE;
                    end
                    S_SHIR: begin
                        ir_sh_r <= {tdi_l, ir_sh_r[3:1]};
                    end
                    S_CDR: begin
                        // Only the selected register loads
                        if (sel_byp) begin
                            byp_r <= 1'b0;
                        end
                        if (sel_id) begin
                            id_sh_r <= ID_WORD;
                        end
                        if (sel_bsr) begin
                            bsr_sh_r <= pad_in;
                        end
                    end
                    S_SHDR: begin
                        // Others hold still while not selected
                        if (sel_byp) begin
                            byp_r <= tdi_l;
                        end
                        if (sel_id) begin
                            id_sh_r <= {tdi_l, id_sh_r[31:1]};
                        end
                        if (sel_bsr) begin
                            bsr_sh_r <= {tdi_l,
                                         bsr_sh_r[BSR_LEN-1:1]};
                        end
                    end
                    default: begin
                        byp_r <= byp_r;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Falling edge: instruction and boundary update, data out
    // ------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ir_cur_r  <= `JTG_OP_IDCODE;
            bsr_upd_r <= {BSR_LEN{1'b0}};
            tdo_r     <= 1'b0;
            tdo_oe_r  <= 1'b0;
        end else if (state_r == S_TLR) begin
            // Reset state always leaves the ID register selected
            ir_cur_r <= `JTG_OP_IDCODE;
            tdo_oe_r <= 1'b0;
        end else if (tck_fall) begin
            if (state_r == S_UIR) begin
                ir_cur_r <= ir_sh_r;
            end
            if (state_r == S_UDR && sel_bsr) begin
                // Preload via sample lands here before external test
                bsr_upd_r <= bsr_sh_r;
            end
            // Data out follows the path chosen by the instruction
            tdo_oe_r <= (state_r == S_SHIR) | (state_r == S_SHDR);
            // Outside the shift states the line holds, so a path change
            // while idle never reaches the pin
            if (state_r == S_SHIR) begin
                tdo_r <= ir_sh_r[0];
            end else if (state_r != S_SHDR) begin
                tdo_r <= tdo_r;
            end else if (sel_bsr) begin
                tdo_r <= bsr_sh_r[0];
            end else if (sel_id) begin
                tdo_r <= id_sh_r[0];
            end else begin
                tdo_r <= byp_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Pad drive mux; registered so pads never see a decode glitch
    // ------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pad_out_r <= {BSR_LEN{1'b0}};
            pad_oe_r  <= {BSR_LEN{1'b0}};
        end else if (ir_cur_r == `JTG_OP_EXTEST) begin
            pad_out_r <= bsr_upd_r;
            pad_oe_r  <= {BSR_LEN{1'b1}};
        end else if (ir_cur_r == `JTG_OP_HIGHZ) begin
            pad_out_r <= core_out;
            pad_oe_r  <= {BSR_LEN{1'b0}};
        end else begin
            // Normal function for every other code
            pad_out_r <= core_out;
            pad_oe_r  <= core_oe;
        end
    end

endmodule // jtg_tap_decode

`default_nettype wire

// >>> verif/jtg_tap_decode_sva.sv
// Checker for the boundary-scan decode block, bound to its ports
`timescale 1ns/1ps
`default_nettype none

module jtg_tap_decode_sva #(
    parameter int BSR_LEN = 8           // Boundary cells
) (
    // Clock and reset
    input wire logic               clk_sys,
    input wire logic               rst,
    // Test port pins
    input wire logic               tck,
    input wire logic               tms,
    input wire logic               tdi,
    input wire logic               trst_n,
    input wire logic               tdo_r,
    input wire logic               tdo_oe_r,
    // Pads
    input wire logic [BSR_LEN-1:0] core_out,
    input wire logic [BSR_LEN-1:0] core_oe,
    input wire logic [BSR_LEN-1:0] pad_in,
    input wire logic [BSR_LEN-1:0] pad_out_r,
    input wire logic [BSR_LEN-1:0] pad_oe_r,
    input wire logic [3:0]         ir_cur_r
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Test reset held long enough to pass the pin filter
    sequence s_trst_held;
        (!trst_n) [*8];
    endsequence

    // Pads copy the core one clock later in functional modes
    property p_follow(logic [3:0] c);
        (ir_cur_r == c) |=> (pad_out_r == $past(core_out))
            && (pad_oe_r == $past(core_oe));
    endproperty

    a_sample_normal: assert property (p_follow(4'h1))
        else $error("pads left core during sample");
    a_idcode_normal: assert property (p_follow(4'h2))
        else $error("pads left core during idcode");
    a_bypass_normal: assert property (p_follow(4'hF))
        else $error("pads left core during bypass");
    a_unlisted_normal: assert property ((ir_cur_r inside {4'h3,
        [4'h5:4'hE]}) |=> (pad_oe_r == $past(core_oe)))
        else $error("unlisted code disturbed pad enables");
    a_extest_drive: assert property ((ir_cur_r == 4'h0)
        |=> (pad_oe_r == '1)) else $error("extest pads not driven");
    a_highz_float: assert property ((ir_cur_r == 4'h4)
        |=> (pad_oe_r == '0)) else $error("high-z pads still driven");
    a_trst_idcode: assert property (s_trst_held |=> ir_cur_r == 4'h2)
        else $error("test reset left no idcode");
    a_trst_quiet: assert property (s_trst_held |-> !tdo_oe_r)
        else $error("serial out driven in test reset");
    a_reset_idcode: assert property ($fell(rst) |-> ir_cur_r == 4'h2)
        else $error("idcode not current after reset");
    a_tdo_quiet: assert property ($changed(tdo_r)
        |-> (tdo_oe_r || $past(tdo_oe_r))) else $error("tdo moved idle");
endmodule // jtg_tap_decode_sva

bind jtg_tap_decode jtg_tap_decode_sva #(.BSR_LEN(BSR_LEN)) u_sva (
    .clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo_r(tdo_r), .tdo_oe_r(tdo_oe_r),
    .core_out(core_out), .core_oe(core_oe), .pad_in(pad_in),
    .pad_out_r(pad_out_r), .pad_oe_r(pad_oe_r), .ir_cur_r(ir_cur_r));
`default_nettype wire

// >>> verif/jtg_ctrl_model.sv
// Behavioural test controller that walks the TAP pins
`timescale 1ns/1ps
`default_nettype none

module jtg_ctrl_model (
    // Clock
    input  wire logic clk_sys,
    // Serial data from the device
    input  wire logic tdo,
    // Test port pins
    output var logic  tck,
    output var logic  tms,
    output var logic  tdi,
    output var logic  trst_n
);
    // Test reset asserted from time zero
    initial begin
        tck = 1'b1;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b0;
    end

    // One test clock of 8 system clocks; tms/tdi move with the fall
    task automatic tick(input logic m, input logic d, output logic q);
        @(posedge clk_sys);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge clk_sys);
        tck <= 1'b1;
        // Three here plus the next call's first edge keeps 8 per period
        repeat (3) @(posedge clk_sys);
        q = tdo;                   // Settled well before the next fall
    endtask

    task automatic set_trst(input logic v);
        @(posedge clk_sys);
        trst_n <= v;
    endtask

    // Five high mode clocks reach the reset state, then idle
    task automatic reset_tap();
        logic q;
        repeat (5) tick(1'b1, ~tdi, q);
        tick(1'b0, ~tdi, q);
    endtask

    // Scan from idle back to idle; unused tdi toggles, never stale
    task automatic scan(input logic ir, input int n,
                        input logic [31:0] din, output logic [31:0] dout);
        logic q;
        dout = '0;
        tick(1'b1, ~tdi, q);
        if (ir) tick(1'b1, ~tdi, q);
        tick(1'b0, ~tdi, q);
        tick(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
        end
        tick(1'b1, ~tdi, q);
        repeat (2) tick(1'b0, ~tdi, q);
    endtask
endmodule // jtg_ctrl_model
`default_nettype wire

// >>> verif/boundary_scan_instruction_decode_test.sv
// Self-checking bench for the boundary-scan decode block
`timescale 1ns/1ps
`default_nettype none
`include "jtg_defines.vh"

module boundary_scan_instruction_decode_test;
    localparam int          BSR_LEN = 8;
    localparam logic [3:0]  VER  = 4'hA;     // Arbitrary value
    localparam logic [15:0] PART = 16'h5A3C; // Arbitrary value
    localparam logic [10:0] MFR  = 11'h2B5;  // Arbitrary value
    localparam logic [31:0] ID_WORD = {VER, PART, MFR, `JTG_ID_LSB_VAL};
    logic               clk_sys = 1'b0;
    logic               rst = 1'b1;
    wire                tck, tms, tdi, trst_n;
    wire                tdo_r, tdo_oe_r;
    wire                tdo_pin = tdo_oe_r ? tdo_r : 1'b1; // Pull-up
    logic [BSR_LEN-1:0] core_out = '0, core_oe = '0, pad_in = '0;
    wire  [BSR_LEN-1:0] pad_out_r, pad_oe_r;
    wire  [3:0]         ir_cur_r;
    logic [31:0]        exp_q[$];
    logic               got_vld = 1'b0;
    logic [31:0]        got_val = '0;
    logic [BSR_LEN-1:0] latch = '0;  // Expected boundary update latch
    int                 errors = 0, checked = 0, cycles = 0;

    always #50 clk_sys = ~clk_sys;

    jtg_tap_decode #(.BSR_LEN(BSR_LEN), .ID_VER(VER), .ID_PART(PART),
        .ID_MFR(MFR)) dut (.clk_sys(clk_sys), .rst(rst), .tck(tck),
        .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo_r(tdo_r),
        .tdo_oe_r(tdo_oe_r), .core_out(core_out), .core_oe(core_oe),
        .pad_in(pad_in), .pad_out_r(pad_out_r), .pad_oe_r(pad_oe_r),
        .ir_cur_r(ir_cur_r));

    jtg_ctrl_model m (.clk_sys(clk_sys), .tdo(tdo_pin), .tck(tck),
        .tms(tms), .tdi(tdi), .trst_n(trst_n));

    // Note an expectation and hand the observed value to the watcher
    task automatic note(input logic [31:0] e, input logic [31:0] g);
        exp_q.push_back(e);
        got_val <= g;
        got_vld <= 1'b1;
        @(posedge clk_sys);
        got_vld <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Watcher: oldest note against each result
    always @(posedge clk_sys) begin
        logic [31:0] e;
        if (got_vld) begin
            e = exp_q.size() ? exp_q.pop_front() : 'x;
            checked++;
            if (got_val !== e) begin
                $display("unexpected at %0t: got %h expected %h",
                         $time, got_val, e);
                errors++;
            end
        end
    end

    function automatic logic [31:0] dr_exp(logic [3:0] c, logic [31:0] d);
        case (c)
            `JTG_OP_EXTEST, `JTG_OP_SAMPLE: return {d[31-BSR_LEN:0], pad_in};
            `JTG_OP_IDCODE: return ID_WORD;
            default: return {d[30:0], 1'b0};
        endcase
    endfunction

    function automatic logic [31:0] pad_exp(logic [3:0] c);
        case (c)
            `JTG_OP_EXTEST: return {16'h0, latch, 8'hFF};
            `JTG_OP_HIGHZ: return 32'h0;
            default: return {16'h0, core_out, core_oe};
        endcase
    endfunction

    task automatic pads(input logic [3:0] c);
        note(pad_exp(c), {16'h0, (c == `JTG_OP_HIGHZ) ? 8'h00 : pad_out_r,
                          pad_oe_r});
    endtask

    task automatic wrap_up();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Hang guard, about six times the expected run
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            wrap_up();
        end
    end

    // Main sequence; sample/preload comes before external test
    initial begin
        logic [31:0] din, dout;
        logic [3:0]  code;
        logic [3:0]  codes[6];
        void'($urandom(32'hEDC2E491));
        codes = '{`JTG_OP_SAMPLE, `JTG_OP_EXTEST, `JTG_OP_IDCODE,
                  `JTG_OP_HIGHZ, `JTG_OP_BYPASS, 4'h5};
        codes[5] = 4'h5 + 4'($urandom_range(0, 9));
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        m.set_trst(1'b1);
        repeat (6) @(posedge clk_sys);
        m.reset_tap();
        note(32'(`JTG_OP_IDCODE), 32'(ir_cur_r));
        m.scan(1'b0, 32, $urandom, dout);
        note(ID_WORD, dout);
        pads(`JTG_OP_IDCODE);
        foreach (codes[k]) begin
            code = codes[k];
            @(posedge clk_sys);
            core_out <= BSR_LEN'($urandom);
            core_oe <= BSR_LEN'($urandom);
            pad_in <= BSR_LEN'($urandom);
            m.scan(1'b1, 4, {28'h0, code}, dout);
            note(32'(`JTG_IR_CAPTURE), dout);
            note(32'(code), 32'(ir_cur_r));
            pads(code);
            din = $urandom;
            m.scan(1'b0, 32, din, dout);
            note(dr_exp(code, din), dout);
            if (code == `JTG_OP_EXTEST || code == `JTG_OP_SAMPLE)
                latch = din[31:32-BSR_LEN];
            pads(code);
        end
        // Mode-select path into the reset state, then a fresh ID read
        m.reset_tap();
        note(32'(`JTG_OP_IDCODE), 32'(ir_cur_r));
        m.scan(1'b0, 32, $urandom, dout);
        note(ID_WORD, dout);
        m.scan(1'b1, 4, {28'h0, `JTG_OP_BYPASS}, dout);
        note(32'(`JTG_IR_CAPTURE), dout);
        note(32'(`JTG_OP_BYPASS), 32'(ir_cur_r));
        m.set_trst(1'b0);
        repeat (10) @(posedge clk_sys);
        m.set_trst(1'b1);
        note(32'(`JTG_OP_IDCODE), 32'(ir_cur_r));
        wrap_up();
    end
endmodule // boundary_scan_instruction_decode_test
`default_nettype wire
